//--- design/tpeb_params.svh
// Purpose: Shared constants of the transmit elastic buffer
// Assumes: Included by the package and by every design module
// Notes: Entry layout is {data, keep, last}, last in bit 0
`ifndef TPEB_PARAMS_SVH
`define TPEB_PARAMS_SVH

`define TPEB_DATA_W 64
`define TPEB_KEEP_W 8
`define TPEB_ENTRY_W 73
`define TPEB_FIFO_DEPTH 32
`define TPEB_COUNT_W 6
`define TPEB_LEVEL_W 7

`define TPEB_LAST_BIT 0
`define TPEB_KEEP_LSB 1
`define TPEB_KEEP_MSB 8
`define TPEB_DATA_LSB 9
`define TPEB_DATA_MSB 72

`define TPEB_START_LIMIT 7'h10
`define TPEB_FULL_GUARD 7'h1E
`define TPEB_PIPE_STAGES 2
`define TPEB_PIPE_TAP 2
`define TPEB_STATE_RESET '0

`endif

//--- design/tpeb_pkg.sv
// Purpose: State type of the transmit elastic buffer top module
// Assumes: Widths come from the params header
// Notes: The top module keeps all of its state in this struct; the FIFO and delay pipe declare their own
`include "tpeb_params.svh"

package tpeb_pkg;

    typedef struct packed {
        logic wr_strobe;
        logic [`TPEB_ENTRY_W-1:0] wr_entry;
        logic in_pkt;
        logic ready;
        logic tvalid;
        logic [`TPEB_DATA_W-1:0] tdata;
        logic [`TPEB_KEEP_W-1:0] tkeep;
        logic tlast;
        logic [`TPEB_COUNT_W-1:0] level;
        logic idle;
        logic overflow;
    } tpeb_main_state_t;

endpackage

//--- design/tpeb_delay_pipe.sv
// Purpose: Shift register giving delayed copies of one level
// Assumes: Input comes from logic on the same clock
// Notes: taps[0] is the input itself, taps[i] is it delayed by i cycles
`include "tpeb_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tpeb_delay_pipe #(
    parameter int STAGES = `TPEB_PIPE_STAGES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Level in, delayed copies out
    input wire logic level_in,
    output logic [STAGES:0] taps
);

    typedef struct packed {
        logic [STAGES:1] sh;
    } tpeb_pipe_state_t;

    tpeb_pipe_state_t st_q;
    tpeb_pipe_state_t st_d;

    assign taps[0] = level_in;

    genvar gi;
    generate
        for (gi = 1; gi <= STAGES; gi++) begin : g_tap
            assign taps[gi] = st_q.sh[gi];
        end
    endgenerate

    always_comb begin
        st_d = st_q;
        st_d.sh = {taps[STAGES-1:0]};
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= `TPEB_STATE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

endmodule
`default_nettype wire

//--- design/tpeb_fifo.sv
// Purpose: Synchronous first-word-fall-through FIFO
// Assumes: One clock; writer honours in_ready
// Notes: out_data shows the head word whenever out_valid is high
`include "tpeb_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tpeb_fifo #(
    parameter int WIDTH = `TPEB_ENTRY_W,
    parameter int DEPTH = `TPEB_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Occupancy
    output logic [$clog2(DEPTH):0] count
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } tpeb_fifo_state_t;

    tpeb_fifo_state_t st_q;
    tpeb_fifo_state_t st_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic do_wr;
    logic do_rd;

    assign count = st_q.wr_ptr - st_q.rd_ptr;
    // Full when pointers differ only in the wrap bit
    assign in_ready = !((st_q.wr_ptr[AW] != st_q.rd_ptr[AW])
                      && (st_q.wr_ptr[AW-1:0] == st_q.rd_ptr[AW-1:0]));
    assign out_valid = (st_q.wr_ptr != st_q.rd_ptr);
    assign out_data = mem[st_q.rd_ptr[AW-1:0]];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always_comb begin
        st_d = st_q;
        if (do_wr) begin
            st_d.wr_ptr = st_q.wr_ptr + 1'b1;
        end
        if (do_rd) begin
            st_d.rd_ptr = st_q.rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= `TPEB_STATE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // Storage needs no reset; pointers guard every read
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[st_q.wr_ptr[AW-1:0]] <= in_data;
        end
    end

endmodule
`default_nettype wire

//--- design/tpeb_tx_elastic_buffer.sv
// Purpose: Transmit elastic buffer between offload engine and MAC
// Assumes: Everything runs on the MAC transmit clock
// Notes: Packets must fit in the FIFO room left at packet start
//
// Function
// - Buffer outgoing beats in a 32-entry FIFO to ride out MAC pauses.
// - Raise upstream ready only while the FIFO fill is below 16.
// - Start a packet only when the one- and two-cycle ready delay taps are both low.
// - Valid and ready stay high every cycle until the last beat.
// - Pulse the write strobe one clock after each accepted beat.
// - FIFO entries are 73 bits: data, byte keep and last flag.
// - After the last beat, hold upstream ready low for 3 cycles.
// - Read the FIFO as soon as it is no longer empty and tready is high.
// - Present tvalid with the word one cycle after each read.
// - Keep the read strobe low while tready is low.
// - Drop the read strobe in the same cycle the FIFO shows empty.
// - Lower tvalid once the final word has been taken.
// - Both sides are 64-bit streams carrying data, keep and last.
// - Run wholly in the MAC transmit clock domain.
`include "tpeb_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tpeb_tx_elastic_buffer (
    // Clock and reset, MAC transmit domain
    input wire logic clk,
    input wire logic sys_rst,

    // Upstream stream from the offload engine
    input wire logic upstream_valid,
    output logic upstream_ready,
    input wire logic [`TPEB_DATA_W-1:0] upstream_data_word,
    input wire logic [`TPEB_KEEP_W-1:0] upstream_byte_keep,
    input wire logic upstream_last_flag,

    // Downstream stream to the MAC
    output logic m_axis_tvalid,
    input wire logic m_axis_tready,
    output logic [`TPEB_DATA_W-1:0] m_axis_tdata,
    output logic [`TPEB_KEEP_W-1:0] m_axis_tkeep,
    output logic m_axis_tlast,

    // Status
    output logic [`TPEB_COUNT_W-1:0] fifo_fill_count,
    output logic buffer_idle,
    output logic fifo_overflow
);

    tpeb_pkg::tpeb_main_state_t st_q;
    tpeb_pkg::tpeb_main_state_t st_d;

    // FIFO side signals
    logic fifo_in_ready;
    logic fifo_not_empty;
    logic fifo_empty_flag;
    logic fifo_read_strobe;
    logic [`TPEB_ENTRY_W-1:0] fifo_head;
    logic [`TPEB_COUNT_W-1:0] fifo_count;

    // Ready history; bit 0 is the live ready, bit 2 is two cycles old
    logic [`TPEB_PIPE_STAGES:0] ready_delay_pipe;

    // Write side helpers
    logic beat_accept;
    logic last_accept;
    logic [`TPEB_LEVEL_W-1:0] level_eff;
    logic start_ok;

    // Count lags one cycle behind the write strobe, so add it back in
    function automatic logic [`TPEB_LEVEL_W-1:0] eff_level(
        input logic [`TPEB_COUNT_W-1:0] cnt,
        input logic pending
    );
        eff_level = {1'b0, cnt} + {{(`TPEB_LEVEL_W-1){1'b0}}, pending};
    endfunction

    tpeb_fifo #(
        .WIDTH(`TPEB_ENTRY_W),
        .DEPTH(`TPEB_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(st_q.wr_strobe),
        .in_ready(fifo_in_ready),
        .in_data(st_q.wr_entry),
        .out_valid(fifo_not_empty),
        .out_ready(fifo_read_strobe),
        .out_data(fifo_head),
        .count(fifo_count)
    );

    tpeb_delay_pipe #(
        .STAGES(`TPEB_PIPE_STAGES)
    ) u_ready_pipe (
        .clk(clk),
        .sys_rst(sys_rst),
        .level_in(st_q.ready),
        .taps(ready_delay_pipe)
    );

    assign fifo_empty_flag = !fifo_not_empty;

    // Drain only while the MAC is taking words; empty stops it at once
    assign fifo_read_strobe = fifo_not_empty && m_axis_tready;

    assign beat_accept = upstream_valid && st_q.ready;
    assign last_accept = beat_accept && upstream_last_flag;
    assign level_eff = eff_level(fifo_count, st_q.wr_strobe);

    // A fresh packet needs room and a quiet ready history; the nearer tap
    // covers a one-beat packet taken on the very first cycle of ready,
    // which would otherwise leave the far tap low and shorten the gap
    assign start_ok = (level_eff < `TPEB_START_LIMIT)
                      && !ready_delay_pipe[`TPEB_PIPE_TAP-1]
                      && !ready_delay_pipe[`TPEB_PIPE_TAP];

    always_comb begin
        st_d = st_q;

        // Upstream beat capture, stored one clock later
        st_d.wr_strobe = beat_accept;
        if (beat_accept) begin
            st_d.wr_entry = {upstream_data_word, upstream_byte_keep,
                             upstream_last_flag};
        end

        // Packet tracking
        if (last_accept) begin
            st_d.in_pkt = 1'b0;
        end else if (beat_accept) begin
            st_d.in_pkt = 1'b1;
        end

        // Upstream ready
        if (last_accept) begin
            // Falls low; the delay tap then keeps it low for the gap
            st_d.ready = 1'b0;
        end else if (st_q.in_pkt || beat_accept) begin
            // Mid-packet ready must not drop; the guard only trips if a
            // packet outgrows the room that existed at its start
            st_d.ready = (level_eff < `TPEB_FULL_GUARD);
        end else if (st_q.ready) begin
            // Already open and waiting for the next packet's first beat
            st_d.ready = (level_eff < `TPEB_START_LIMIT);
        end else begin
            st_d.ready = start_ok;
        end

        // Downstream presentation
        if (fifo_read_strobe) begin
            st_d.tvalid = 1'b1;
            st_d.tdata = fifo_head[`TPEB_DATA_MSB:`TPEB_DATA_LSB];
            st_d.tkeep = fifo_head[`TPEB_KEEP_MSB:`TPEB_KEEP_LSB];
            st_d.tlast = fifo_head[`TPEB_LAST_BIT];
        end else if (m_axis_tready) begin
            // Word taken and nothing behind it
            st_d.tvalid = 1'b0;
        end
        // With tready low nothing above changes the word

        // Status
        st_d.level = fifo_count;
        st_d.idle = !st_q.in_pkt && fifo_empty_flag && !st_q.tvalid;
        // Sticky: a write into a full FIFO means a packet was too long
        if (st_q.wr_strobe && !fifo_in_ready) begin
            st_d.overflow = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= `TPEB_STATE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign upstream_ready = st_q.ready;
    assign m_axis_tvalid = st_q.tvalid;
    assign m_axis_tdata = st_q.tdata;
    assign m_axis_tkeep = st_q.tkeep;
    assign m_axis_tlast = st_q.tlast;
    assign fifo_fill_count = st_q.level;
    assign buffer_idle = st_q.idle;
    assign fifo_overflow = st_q.overflow;

endmodule
`default_nettype wire

//--- tb/tpeb_chk.sv
// Purpose: Port checks of the transmit elastic buffer
// Assumes: Packets are short enough to stay below the mid-packet guard
// Notes: Bound onto the top module after the checker
`include "tpeb_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tpeb_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Upstream
    input wire logic upstream_valid,
    input wire logic upstream_ready,
    input wire logic upstream_last_flag,
    // Downstream
    input wire logic m_axis_tvalid,
    input wire logic m_axis_tready,
    input wire logic [`TPEB_DATA_W-1:0] m_axis_tdata,
    input wire logic [`TPEB_KEEP_W-1:0] m_axis_tkeep,
    input wire logic m_axis_tlast,
    // Status
    input wire logic [`TPEB_COUNT_W-1:0] fifo_fill_count
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_RST_CLEAR: assert property ($fell(sys_rst) |->
        !upstream_ready && !m_axis_tvalid && fifo_fill_count == 6'h00)
        else $error("outputs not clear after reset");
    AST_GAP: assert property (upstream_valid && upstream_ready && upstream_last_flag
        |=> !upstream_ready [*3]) else $error("packet gap too short");
    AST_IN_PKT: assert property (upstream_valid && upstream_ready && !upstream_last_flag
        |=> upstream_ready) else $error("ready dropped inside packet");
    AST_START_ROOM: assert property ($rose(upstream_ready) |->
        fifo_fill_count < 6'h10) else $error("ready rose with fill at limit");
    AST_HOLD: assert property (m_axis_tvalid && !m_axis_tready |=> m_axis_tvalid &&
        $stable(m_axis_tdata) && $stable(m_axis_tkeep) && $stable(m_axis_tlast))
        else $error("word changed while stalled");
    AST_NO_FETCH: assert property (!m_axis_tvalid && !m_axis_tready |=>
        !m_axis_tvalid) else $error("word fetched while tready low");
    AST_READ_LAT: assert property ($rose(m_axis_tvalid) |->
        $past(m_axis_tready)) else $error("tvalid rose without a read");
    AST_DEPTH: assert property (fifo_fill_count <= 6'h20)
        else $error("fill beyond depth");

    COV_GAP: cover property (upstream_valid && upstream_ready && upstream_last_flag);
    COV_STALL: cover property (m_axis_tvalid && !m_axis_tready);
    COV_REFUSE: cover property (!upstream_ready && fifo_fill_count >= 6'h10);
endmodule

bind tpeb_tx_elastic_buffer tpeb_chk u_chk (.clk(clk), .sys_rst(sys_rst),
    .upstream_valid(upstream_valid), .upstream_ready(upstream_ready),
    .upstream_last_flag(upstream_last_flag), .m_axis_tvalid(m_axis_tvalid),
    .m_axis_tready(m_axis_tready), .m_axis_tdata(m_axis_tdata),
    .m_axis_tkeep(m_axis_tkeep), .m_axis_tlast(m_axis_tlast),
    .fifo_fill_count(fifo_fill_count));
`default_nettype wire

//--- tb/tpeb_mac_model.sv
// Purpose: MAC sink that paces tready
// Assumes: mode 0 always ready, 1 stalls 2 of 5 cycles, 2 holds off
// Notes: Changes off the sampling edge so the block sees a settled level
`timescale 1ns/1ps
`default_nettype none

module tpeb_mac_model (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Pacing
    input wire logic [1:0] mode,
    output logic tready
);
    logic [2:0] cnt;
    initial begin
        tready = 1'b0;
        cnt = 3'h0;
    end
    always @(negedge clk) begin
        cnt <= (cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
        tready <= !sys_rst && (mode == 2'h0 || (mode == 2'h1 && cnt > 3'h1));
    end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Purpose: Self-checking bench of the transmit elastic buffer
// Assumes: Inputs change at the falling edge
// Notes: Every taken word is scored against the queue of sent beats
`include "tpeb_params.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk, sys_rst, upstream_valid, upstream_ready, upstream_last_flag;
    logic [63:0] upstream_data_word, m_axis_tdata;
    logic [7:0] upstream_byte_keep, m_axis_tkeep;
    logic m_axis_tvalid, m_axis_tready, m_axis_tlast, buffer_idle, fifo_overflow;
    logic [5:0] fifo_fill_count;
    logic [1:0] mode;
    logic [72:0] exp_q[$];
    int failures, checks;

    tpeb_tx_elastic_buffer DUT (.clk(clk), .sys_rst(sys_rst),
        .upstream_valid(upstream_valid), .upstream_ready(upstream_ready),
        .upstream_data_word(upstream_data_word), .upstream_byte_keep(upstream_byte_keep),
        .upstream_last_flag(upstream_last_flag), .m_axis_tvalid(m_axis_tvalid),
        .m_axis_tready(m_axis_tready), .m_axis_tdata(m_axis_tdata),
        .m_axis_tkeep(m_axis_tkeep), .m_axis_tlast(m_axis_tlast),
        .fifo_fill_count(fifo_fill_count), .buffer_idle(buffer_idle),
        .fifo_overflow(fifo_overflow));
    tpeb_mac_model u_mac (.clk(clk), .sys_rst(sys_rst), .mode(mode), .tready(m_axis_tready));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string name, input logic [72:0] seen, input logic [72:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    always @(posedge clk) begin
        if (!sys_rst && m_axis_tvalid === 1'b1 && m_axis_tready === 1'b1) begin
            if (exp_q.size() == 0)
                check("spare word", 73'h1, 73'h0);
            else
                check("word", {m_axis_tdata, m_axis_tkeep, m_axis_tlast}, exp_q.pop_front());
        end
    end

    task automatic send_pkt(input int n, input logic [7:0] tag);
        int w;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            upstream_valid = 1'b1;
            upstream_data_word = {tag, 56'(i)};
            upstream_byte_keep = (i == n - 1) ? 8'h0F : 8'hFF;
            upstream_last_flag = (i == n - 1);
            exp_q.push_back({upstream_data_word, upstream_byte_keep, upstream_last_flag});
            w = 0;
            do begin @(posedge clk); w++; end while (upstream_ready !== 1'b1 && w < 200);
            check("ready wait", 73'(w < 200), 73'h1);
        end
        @(negedge clk);
        upstream_valid = 1'b0;
        upstream_last_flag = 1'b0;
    endtask

    task automatic drain();
        int w;
        w = 0;
        while (exp_q.size() != 0 && w < 500) begin @(negedge clk); w++; end
        repeat (3) @(negedge clk);
        check("words left", 73'(exp_q.size()), 73'h0);
        check("idle", 73'(buffer_idle), 73'h1);
        check("tvalid closed", 73'(m_axis_tvalid), 73'h0);
        check("no overflow", 73'(fifo_overflow), 73'h0);
    endtask

    task automatic t_reset();
        sys_rst = 1'b1;
        exp_q.delete();
        repeat (3) @(negedge clk);
        check("ready in reset", 73'(upstream_ready), 73'h0);
        check("tvalid in reset", 73'(m_axis_tvalid), 73'h0);
        check("fill in reset", 73'(fifo_fill_count), 73'h0);
        sys_rst = 1'b0;
    endtask

    // One-beat and four-beat packets, gap measured after each
    task automatic t_fast();
        mode = 2'h0;
        for (int p = 1; p <= 4; p += 3) begin
            send_pkt(p, 8'(p));
            for (int k = 0; k < 4; k++) begin
                check("gap ready", 73'(upstream_ready), 73'(k == 3));
                @(negedge clk);
            end
        end
        drain();
    endtask

    // MAC pauses mid-packet, then a reset lands with words still queued
    task automatic t_stall();
        mode = 2'h1;
        send_pkt(10, 8'hA0);
        send_pkt(10, 8'hA1);
        drain();
        send_pkt(6, 8'hA2);
        t_reset();
        drain();
    endtask

    // MAC holds off until the start room is used up
    task automatic t_fill();
        mode = 2'h2;
        send_pkt(14, 8'hB0);
        send_pkt(3, 8'hB1);
        @(negedge clk);
        upstream_valid = 1'b1;
        repeat (6) @(negedge clk);
        check("ready at limit", 73'(upstream_ready), 73'h0);
        check("fill at limit", 73'(fifo_fill_count), 73'h11);
        upstream_valid = 1'b0;
        mode = 2'h0;
        drain();
    endtask

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Whole run is well under a thousand cycles; allow twenty thousand
    initial begin
        #1000000;
        failures++;
        tally_and_finish();
    end

    initial begin
        sys_rst = 1'b1;
        upstream_valid = 1'b0;
        upstream_data_word = 64'h0;
        upstream_byte_keep = 8'h00;
        upstream_last_flag = 1'b0;
        mode = 2'h0;
        failures = 0;
        checks = 0;
        t_reset();
        t_fast();
        t_stall();
        t_fill();
        tally_and_finish();
    end
endmodule
`default_nettype wire
